// ===== core/lmfc_release_pkg.sv
// shared constants and types of the lmfc release block
package lmfc_release_pkg;
   // datapath shape
   localparam int NUM_LANES    = 2;
   localparam int LANE_W       = 32;
   localparam int OCTETS_PER_CYC = 4;
   localparam int FIFO_DEPTH   = 32;
   localparam int LEVEL_W      = 6;
   localparam int FILL_W       = 10;
   // multiframe length in core-clock cycles (32 octets)
   localparam int LMFC_CYCLES  = 8;
   localparam int LMFC_CNT_W   = 3;
   localparam logic [LMFC_CNT_W-1:0] LMFC_LAST = 3'h7;
   // lmfc_offset_cycles and sysref_always settings
   localparam int OFFSET_W     = 4;
   localparam logic [OFFSET_W-1:0] OFFSET_RST = 4'h0;
   localparam logic                ALWAYS_RST = 1'h0;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LMFC   = 8'h08;
   localparam logic [7:0] ADDR_FILL0  = 8'h10;
   // control field positions
   localparam int CTRL_OFFSET_LSB = 0;
   localparam int CTRL_ALWAYS_BIT = 4;
   localparam int CTRL_RELINK_BIT = 8;
   // status field positions
   localparam int STAT_STATE_LSB   = 0;
   localparam int STAT_ALIGNED_BIT = 2;
   localparam int STAT_SEEN_BIT    = 3;
   localparam int STAT_OFFSET_LSB  = 8;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef enum logic [1:0] {
      ST_WAIT_SYSREF = 2'b00,
      ST_WAIT_DATA   = 2'b01,
      ST_STREAM      = 2'b10
   } rel_state_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
   } ahb_req_t;

   typedef struct packed {
      logic [NUM_LANES-1:0]             valid;
      logic [NUM_LANES-1:0][LANE_W-1:0] data;
   } lane_in_t;
endpackage

// ===== core/elastic_fifo.sv
// per-lane alignment fifo with registered read data
`timescale 1ns/1ns
module elastic_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32,
   parameter int LW    = 6
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // words held, output register included
   output logic [LW-1:0]         level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_r;
   logic [AW-1:0]    rptr_r;
   logic [LW-1:0]    cnt_r;
   logic             valid_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != LW'(DEPTH));
   assign push      = in_valid && in_ready;
   assign pop       = (cnt_r != '0) && (!valid_r || out_ready);
   assign out_valid = valid_r;
   assign level     = cnt_r + LW'(valid_r);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + AW'(1);
         end
         if (pop) begin
            rptr_r <= rptr_r + AW'(1);
         end
         cnt_r <= cnt_r + LW'(push) - LW'(pop);
      end
   end

   // head word sits in a register so the drain side sees flop outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         valid_r  <= 1'b0;
         out_data <= '0;
      end else if (pop) begin
         valid_r  <= 1'b1;
         out_data <= mem[rptr_r];
      end else if (out_ready) begin
         valid_r  <= 1'b0;
      end
   end
endmodule

// ===== core/lmfc_release.sv
// receive lmfc generation, lane alignment buffering and deterministic release
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module lmfc_release
   import lmfc_release_pkg::*;
(
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  srst,
   // ahb-lite register slave
   input  wire lmfc_release_pkg::ahb_req_t            ahb_req,
   input  wire logic                                  hready,
   input  wire logic [31:0]                           hwdata,
   output logic [31:0]                                hrdata,
   output logic                                       hreadyout,
   output logic                                       hresp,
   // sysref and lmfc
   input  wire logic                                  sysref,
   output logic                                       lmfc_boundary,
   // lane input stream
   input  wire lmfc_release_pkg::lane_in_t            lane_in,
   output logic [lmfc_release_pkg::NUM_LANES-1:0]     lane_ready,
   // released output stream
   output logic                                       out_valid,
   input  wire logic                                  out_ready,
   output logic [lmfc_release_pkg::NUM_LANES*lmfc_release_pkg::LANE_W-1:0] out_data
);
   import lmfc_release_pkg::*;

   // register state
   logic [OFFSET_W-1:0] lmfc_offset_cycles_r;
   logic                ctrl_always_r;
   logic                relink_r;
   logic                link_rst;
   logic                wr_pend_r;
   logic [7:0]          wr_addr_r;
   logic [31:0]         rd_mux;
   logic                addr_phase;

   // lmfc state
   logic [OFFSET_W-1:0]   offset_active_r;
   logic                  sysref_d_r;
   logic                  sysref_edge;
   logic                  used_evt;
   logic                  seen_r;
   logic                  pend_r;
   logic [OFFSET_W-1:0]   dly_r;
   logic                  align_fire;
   logic                  aligned_r;
   logic [LMFC_CNT_W-1:0] lmfc_cnt_r;
   logic [4:0]            since_r;

   // release state
   rel_state_t                       state_r;
   logic                             release_now;
   logic                             all_valid;
   logic [NUM_LANES-1:0]             lane_out_valid;
   logic [NUM_LANES-1:0][LEVEL_W-1:0] lane_level;
   logic [NUM_LANES-1:0][FILL_W-1:0] fill_r;
   logic                             drain;

   // ---------------- ahb-lite slave: zero wait states, always okay
   assign hreadyout  = 1'b1;
   assign hresp      = HRESP_OKAY;
   assign addr_phase = ahb_req.hsel && ahb_req.htrans[1] && hready;
   assign link_rst   = srst || relink_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else if (hready) begin
         wr_pend_r <= addr_phase && ahb_req.hwrite;
         wr_addr_r <= ahb_req.haddr[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lmfc_offset_cycles_r <= OFFSET_RST;
         ctrl_always_r <= ALWAYS_RST;
         relink_r      <= 1'b0;
      end else begin
         relink_r <= 1'b0;
         if (wr_pend_r && wr_addr_r == ADDR_CTRL) begin
            lmfc_offset_cycles_r <= hwdata[CTRL_OFFSET_LSB +: OFFSET_W];
            ctrl_always_r <= hwdata[CTRL_ALWAYS_BIT];
            relink_r      <= hwdata[CTRL_RELINK_BIT];
         end
      end
   end

   always_comb begin
      rd_mux = '0;
      if (ahb_req.haddr[7:0] == ADDR_CTRL) begin
         rd_mux[CTRL_OFFSET_LSB +: OFFSET_W] = lmfc_offset_cycles_r;
         rd_mux[CTRL_ALWAYS_BIT]             = ctrl_always_r;
      end else if (ahb_req.haddr[7:0] == ADDR_STATUS) begin
         rd_mux[STAT_STATE_LSB +: 2]          = state_r;
         rd_mux[STAT_ALIGNED_BIT]             = aligned_r;
         rd_mux[STAT_SEEN_BIT]                = seen_r;
         rd_mux[STAT_OFFSET_LSB +: OFFSET_W]  = offset_active_r;
      end else if (ahb_req.haddr[7:0] == ADDR_LMFC) begin
         rd_mux[LMFC_CNT_W-1:0] = lmfc_cnt_r;
      end else begin
         for (int i = 0; i < NUM_LANES; i++) begin
            if (ahb_req.haddr[7:0] == ADDR_FILL0 + 8'(4 * i)) begin
               rd_mux[FILL_W-1:0] = fill_r[i];
            end
         end
      end
   end

   // read data is sampled in the address phase, so a read right behind a write sees the old value
   always_ff @(posedge clk) begin
      if (srst) begin
         hrdata <= '0;
      end else if (addr_phase && !ahb_req.hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ---------------- sysref event handling and delay
   assign sysref_edge = sysref && !sysref_d_r;
   assign used_evt    = sysref_edge && (ctrl_always_r || !seen_r) && !link_rst;

   always_ff @(posedge clk) begin
      if (link_rst) begin
         sysref_d_r <= 1'b0;
         seen_r     <= 1'b0;
      end else begin
         sysref_d_r <= sysref;
         if (used_evt) begin
            seen_r <= 1'b1;
         end
      end
   end

   // delay setting is only latched on reset, so a live change cannot slip the lmfc
   always_ff @(posedge clk) begin
      if (srst) begin
         offset_active_r <= OFFSET_RST;
      end else if (relink_r) begin
         offset_active_r <= lmfc_offset_cycles_r;
      end
   end

   // whole-cycle delay from event to counter reset; each cycle is four octets
   assign align_fire = (used_evt && offset_active_r == '0) || (pend_r && dly_r == '0);

   always_ff @(posedge clk) begin
      if (link_rst) begin
         pend_r <= 1'b0;
         dly_r  <= '0;
      end else if (used_evt && offset_active_r != '0) begin
         pend_r <= 1'b1;
         dly_r  <= offset_active_r - OFFSET_W'(1);
      end else if (pend_r) begin
         if (dly_r == '0) begin
            pend_r <= 1'b0;
         end else begin
            dly_r <= dly_r - OFFSET_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (link_rst) begin
         aligned_r  <= 1'b0;
         lmfc_cnt_r <= '0;
      end else if (align_fire) begin
         aligned_r  <= 1'b1;
         lmfc_cnt_r <= LMFC_CNT_W'(1);
      end else begin
         lmfc_cnt_r <= lmfc_cnt_r + LMFC_CNT_W'(1);
      end
   end

   // boundary in the fire cycle itself, then every multiframe after
   assign lmfc_boundary = align_fire || (aligned_r && lmfc_cnt_r == '0);

   // ---------------- lane alignment buffers
   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++) begin : lane_g
         elastic_fifo #(
            .WIDTH (LANE_W),
            .DEPTH (FIFO_DEPTH),
            .LW    (LEVEL_W)
         ) u_fifo (
            .clk       (clk),
            .srst      (link_rst),
            .in_valid  (lane_in.valid[g]),
            .in_ready  (lane_ready[g]),
            .in_data   (lane_in.data[g]),
            .out_valid (lane_out_valid[g]),
            .out_ready (drain),
            .out_data  (out_data[g*LANE_W +: LANE_W]),
            .level     (lane_level[g])
         );
      end
   endgenerate

   // ---------------- release control
   assign all_valid   = &lane_out_valid;
   assign release_now = (state_r == ST_WAIT_DATA) && lmfc_boundary && all_valid;
   assign out_valid   = ((state_r == ST_STREAM) || release_now) && all_valid;
   // nothing leaves a buffer before release; a stalled sink backs up into lane_ready
   assign drain       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (link_rst) begin
         state_r <= ST_WAIT_SYSREF;
      end else begin
         unique case (state_r)
            ST_WAIT_SYSREF: begin
               if (align_fire) begin
                  state_r <= ST_WAIT_DATA;
               end
            end
            ST_WAIT_DATA: begin
               if (release_now) begin
                  state_r <= ST_STREAM;
               end
            end
            ST_STREAM: begin
               state_r <= ST_STREAM;
            end
            default: begin
               state_r <= ST_WAIT_SYSREF;
            end
         endcase
      end
   end

   // fill in octets, frozen at the release boundary
   always_ff @(posedge clk) begin
      if (link_rst) begin
         fill_r <= '0;
      end else if (release_now) begin
         for (int i = 0; i < NUM_LANES; i++) begin
            fill_r[i] <= FILL_W'({lane_level[i], 2'b00});
         end
      end
   end

   // ---------------- checks
   always_ff @(posedge clk) begin
      if (link_rst || used_evt) begin
         since_r <= '0;
      end else if (since_r != 5'h1f) begin
         since_r <= since_r + 5'h1;
      end
   end

   sequence quiet_mf_s;
      lmfc_boundary ##1 (!align_fire && !link_rst)[*7];
   endsequence

   offset_delay_a: assert property (@(posedge clk) disable iff (link_rst)
      (align_fire && !used_evt) |-> (5'(offset_active_r) == since_r + 5'h1))
      else $error("lmfc reset not offset by the programmed cycles");
   four_octet_step_a: assert property (@(posedge clk) disable iff (link_rst)
      (used_evt && offset_active_r == 4'h1 && !ctrl_always_r) |=> align_fire)
      else $error("one cycle of delay did not move boundary by one cycle");
   fixed_period_a: assert property (@(posedge clk) disable iff (link_rst)
      quiet_mf_s |=> lmfc_boundary)
      else $error("lmfc boundary period not fixed");
   zero_out_delay_a: assert property (@(posedge clk) disable iff (link_rst)
      release_now |-> out_valid)
      else $error("output lagged the release boundary");
   boundary_release_a: assert property (@(posedge clk) disable iff (link_rst)
      (state_r != ST_STREAM && out_valid) |-> lmfc_boundary ##1 (state_r == ST_STREAM))
      else $error("first output not on a boundary");
   hold_data_a: assert property (@(posedge clk) disable iff (link_rst)
      (state_r != ST_STREAM && !release_now) |-> !drain)
      else $error("lane data left buffer before release");
   fill_capture_a: assert property (@(posedge clk) disable iff (link_rst)
      release_now |=> fill_r[0] == FILL_W'({$past(lane_level[0]), 2'b00}))
      else $error("fill value not captured in octets at release");
   fill_hold_a: assert property (@(posedge clk) disable iff (link_rst)
      (state_r == ST_STREAM) |=> $stable(fill_r))
      else $error("fill value changed after release");
   offset_latch_a: assert property (@(posedge clk) disable iff (srst)
      !relink_r |=> $stable(offset_active_r))
      else $error("delay setting changed without reset");
endmodule

// ===== verification/lane_source_model.sv
// lane source model: transmitter side driving sysref and lane words
`timescale 1ns/1ns
module lane_source_model
   import lmfc_release_pkg::*;
(
   // clock
   input  wire logic                          clk,
   // towards the receiver
   input  wire logic [NUM_LANES-1:0]          lane_ready,
   output logic                               sysref,
   output lmfc_release_pkg::lane_in_t         lane_in
);
   initial begin
      sysref  = 1'b0;
      lane_in = '0;
   end

   // only the rising edge counts, so the level is simply dropped later
   task automatic pulse_sysref();
      sysref <= 1'b1;
      fork
         begin
            repeat (4) @(posedge clk);
            sysref <= 1'b0;
         end
      join_none
   endtask

   // start words now, just after a boundary, inside the arrival window
   // idle data is inverted so a stale word never looks valid
   task automatic burst(input int k0, input int k1);
      int left [NUM_LANES];
      left[0] = k0;
      left[1] = k1;
      while (left[0] + left[1] > 0 || lane_in.valid != '0) begin
         for (int l = 0; l < NUM_LANES; l++) begin
            if (lane_in.valid[l] && lane_ready[l]) left[l]--;
            if (!(lane_in.valid[l] && !lane_ready[l]))
               lane_in.data[l] <= (left[l] > 0) ? $urandom : ~lane_in.data[l];
            lane_in.valid[l] <= (left[l] > 0);
         end
         @(posedge clk);
      end
   endtask
endmodule

// ===== verification/rx_lmfc_release_control_tb_top.sv
// self-checking bench for the lmfc release block
`timescale 1ns/1ns
module rx_lmfc_release_latency_control_tb_top
   import lmfc_release_pkg::*;
;
   logic                          clk = 1'b0;
   logic                          srst = 1'b1;
   ahb_req_t                      ahb_req = '0;
   logic [31:0]                   hwdata = '0;
   logic [31:0]                   hrdata;
   logic                          hreadyout;
   logic                          hresp;
   logic                          hready;
   logic                          sysref;
   logic                          lmfc_boundary;
   lane_in_t                      lane_in;
   logic [NUM_LANES-1:0]          lane_ready;
   logic                          out_valid;
   logic                          out_ready = 1'b0;
   logic [NUM_LANES*LANE_W-1:0]   out_data;
   int                            mismatches = 0;
   int                            total_checks = 0;
   logic [31:0]                   q [NUM_LANES][$];

   always #20 clk = ~clk;
   assign hready = hreadyout;

   lmfc_release u_dut (
      .clk(clk), .srst(srst), .ahb_req(ahb_req), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sysref(sysref),
      .lmfc_boundary(lmfc_boundary), .lane_in(lane_in), .lane_ready(lane_ready),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
   );

   lane_source_model u_tx (
      .clk(clk), .lane_ready(lane_ready), .sysref(sysref), .lane_in(lane_in)
   );

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude();
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // every open-ended wait goes through here, so a hang ends the run
   task automatic step(inout int n);
      @(posedge clk);
      n++;
      if (n > 200) begin
         mismatches++;
         conclude();
      end
   endtask

   task automatic wait_bnd(output int n);
      n = -1;
      do step(n); while (lmfc_boundary !== 1'b1);
   endtask

   // single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      ahb_req <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: HTRANS_NONSEQ, hwrite: w, hsize: 3'h2};
      do step(n); while (hready !== 1'b1);
      ahb_req <= '0;
      hwdata  <= wd;
      do step(n); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", 64'(HRESP_OKAY), 64'(hresp));
   endtask

   // reference queues: pushed on lane accept, popped on output accept
   always @(posedge clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         chk("out_data", {q[1][0], q[0][0]}, out_data);
         void'(q[0].pop_front());
         void'(q[1].pop_front());
      end
      for (int l = 0; l < NUM_LANES; l++)
         if (lane_in.valid[l] && lane_ready[l]) q[l].push_back(lane_in.data[l]);
   end

   initial begin
      int o;
      int k0;
      int k1;
      int n;
      logic [31:0] v;
      logic [31:0] f0;
      logic [31:0] f1;
      void'($urandom(4));
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      ahb(ADDR_CTRL, 1'b0, 32'h0, v);
      chk("ctrl reset", 64'({ALWAYS_RST, OFFSET_RST}), 64'(v[4:0]));
      ahb(8'h20, 1'b1, 32'hffffffff, v);
      ahb(8'h20, 1'b0, 32'h0, v);
      chk("unmapped", 64'h0, 64'(v));
      for (int r = 0; r < 4; r++) begin
         o = (r == 0) ? 0 : (r == 1) ? 15 : (r == 2) ? 1 : $urandom_range(2, 14);
         k0 = $urandom_range(1, 6);
         k1 = $urandom_range(1, 6);
         ahb(ADDR_CTRL, 1'b1, 32'h100 | 32'(o), v);
         repeat (2) @(posedge clk);
         q[0].delete();
         q[1].delete();
         ahb(ADDR_STATUS, 1'b0, 32'h0, v);
         chk("status idle", 64'({4'(o), 4'h0}), 64'({v[11:8], v[3:0]}));
         u_tx.pulse_sysref();
         wait_bnd(n);
         chk("lmfc_offset_cycles", 64'(o), 64'(n));
         wait_bnd(n);
         chk("lmfc period", 64'(LMFC_CYCLES - 1), 64'(n));
         fork
            u_tx.burst(k0, k1);
         join_none
         n = -1;
         do step(n); while (out_valid !== 1'b1);
         chk("release on boundary", 64'h1, 64'(lmfc_boundary));
         chk("release delay", 64'(LMFC_CYCLES - 1), 64'(n));
         ahb(ADDR_LMFC, 1'b0, 32'h0, v);
         chk("lmfc count", 64'h1, 64'(v));
         ahb(ADDR_STATUS, 1'b0, 32'h0, v);
         chk("status stream", 64'he, 64'(v[3:0]));
         ahb(ADDR_FILL0, 1'b0, 32'h0, f0);
         chk("fill lane0", 64'(k0 * OCTETS_PER_CYC), 64'(f0));
         ahb(ADDR_FILL0 + 8'h04, 1'b0, 32'h0, f1);
         chk("fill lane1", 64'(k1 * OCTETS_PER_CYC), 64'(f1));
         chk("fill min", 64'(((k0 < k1) ? k0 : k1) * OCTETS_PER_CYC), 64'((f0 < f1) ? f0 : f1));
         // offset change without relink must not reach the lmfc
         ahb(ADDR_CTRL, 1'b0 | 1'b1, 32'(o ^ 1), v);
         ahb(ADDR_STATUS, 1'b0, 32'h0, v);
         chk("offset held", 64'(o), 64'(v[11:8]));
         out_ready <= 1'b1;
         n = 0;
         while (q[0].size() > 0 && q[1].size() > 0) step(n);
         repeat (2) @(posedge clk);
         chk("stall when dry", 64'h0, 64'(out_valid));
         out_ready <= 1'b0;
         ahb(ADDR_FILL0, 1'b0, 32'h0, v);
         chk("fill frozen", 64'(f0), 64'(v));
      end
      // a second sysref realigns only with sysref_always set; otherwise the period runs on
      for (int a = 0; a < 2; a++) begin
         ahb(ADDR_CTRL, 1'b1, 32'h100 | 32'(a << CTRL_ALWAYS_BIT), v);
         repeat (2) @(posedge clk);
         u_tx.pulse_sysref();
         wait_bnd(n);
         chk("first sysref", 64'h0, 64'(n));
         repeat (5) @(posedge clk);
         u_tx.pulse_sysref();
         wait_bnd(n);
         chk("second sysref", (a == 1) ? 64'h0 : 64'(LMFC_CYCLES - 6), 64'(n));
         // let sysref fall first, else the reset below would see a fresh edge
         repeat (4) @(posedge clk);
      end
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      ahb(ADDR_STATUS, 1'b0, 32'h0, v);
      chk("status after reset", 64'h0, 64'({v[11:8], v[3:0]}));
      ahb(ADDR_FILL0, 1'b0, 32'h0, v);
      chk("fill after reset", 64'h0, 64'(v));
      chk("lane ready", 64'h3, 64'(lane_ready));
      conclude();
   end
endmodule
